//--- design/srtf_framer.sv
// receive termination framer with its input fifo
// Overview of operation
// - buffer bytes, release as one host block
// - type bits: char, message, gap, length
// - type zero selects stream mode
// - stream mode forwards every byte immediately
// - any enabled condition releases the block
// - terminator byte releases block including itself
// - length limit releases, remainder kept
// - full buffer forces a transfer
// - transfers split into host-sized pages
// - modem lines used only when enabled
// - terminator count plus six terminator values
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns

module srtf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,   // system clock
  input  wire logic             rst,       // async reset, high
  input  wire logic             in_valid,  // write side valid
  output      logic             in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word in
  output      logic             out_valid, // word available
  input  wire logic             out_ready, // reader takes word
  output      logic [WIDTH-1:0] out_data   // word out
);
  localparam int AW = $clog2(DEPTH);
  // count kept beside the pointers so full and empty never alias
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } srtf_fifo_s;
  srtf_fifo_s s_q, s_d;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : wrap_inc

  // push, pop and honest full/empty
  always_comb begin
    s_d       = s_q;
    in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
    out_valid = (s_q.cnt != '0);
    out_data  = s_q.mem[s_q.rp];
    if (in_valid && in_ready) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = wrap_inc(s_q.wp);
    end
    if (out_valid && out_ready) begin
      s_d.rp = wrap_inc(s_q.rp);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(in_valid && in_ready) - (AW+1)'(out_valid && out_ready);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : srtf_fifo

module srtf_framer
  import srtf_pkg::*;
#(
  parameter int BUF_BYTES  = srtf_pkg::RX_BUF_BYTES,
  parameter int PAGE_BYTES = srtf_pkg::HOST_PAGE_BYTES,
  parameter int FIFO_DEPTH = srtf_pkg::FIFO_WORDS,
  parameter int TICK_CYC   = srtf_pkg::TICK_CYCLES
) (
  input  wire logic                  ref_clk,         // 10 MHz system clock
  input  wire logic                  rst,             // async reset, high
  input  wire srtf_pkg::srtf_avs_req_s avs_req,       // avalon request
  output      logic [31:0]           avs_readdata,    // avalon read data
  output      logic                  avs_waitrequest, // avalon wait
  input  wire logic                  rx_valid,        // byte from serial side
  input  wire logic [7:0]            rx_data,         // received byte
  output      logic                  rx_ready,        // fifo has room
  input  wire logic                  cts_in,          // modem clear to send
  output      logic                  rts_out,         // modem request to send
  output      logic                  blk_valid,       // host block byte valid
  output      srtf_pkg::srtf_blk_s   blk,             // byte and end of page
  input  wire logic                  blk_ready        // host takes byte
);
  import srtf_pkg::*;
  localparam int CW = $clog2(BUF_BYTES + 1);
  localparam int TW = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic [BUF_BYTES-1:0][7:0] mem;
    logic [CW-1:0]             cnt;
    logic [CW-1:0]             idx;
    srtf_state_e               st;
    srtf_cfg_s                 cfg;
    logic [TW-1:0]             tick;
    logic [TMO_W-1:0]          gap_ms;
    logic [TMO_W-1:0]          msg_ms;
    logic                      ack;
    logic [31:0]               rdata;
    logic [7:0]                blk_cnt;
  } srtf_top_s;
  srtf_top_s s_q, s_d;

  logic       q_valid;
  logic       q_ready;
  logic [7:0] q_data;
  logic       pop;
  logic       rel_now;
  logic       char_hit;

  function automatic logic [TMO_W-1:0] sat_inc(input logic [TMO_W-1:0] v);
    sat_inc = (v == '1) ? v : v + 1'b1;
  endfunction : sat_inc

  // compare a byte against the active terminators
  function automatic logic term_match(input srtf_cfg_s c, input logic [7:0] b);
    term_match = 1'b0;
    for (int i = 0; i < MAX_TERM_CHARS; i++) begin
      if (3'(i) < c.term_cnt && c.term_chars[i] == b) begin
        term_match = 1'b1;
      end
    end
  endfunction : term_match

  function automatic logic is_page_end(input logic [CW-1:0] i);
    is_page_end = ((32'(i) + 1) % PAGE_BYTES) == 0;
  endfunction : is_page_end

  srtf_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   (rx_data),
    .out_valid (q_valid),
    .out_ready (q_ready),
    .out_data  (q_data)
  );

  // framing, timers and register slave
  always_comb begin
    logic        tick_p;
    logic [CW-1:0] ncnt;
    tick_p          = 1'b0;
    ncnt            = s_q.cnt + 1'b1;
    s_d             = s_q;
    q_ready         = (s_q.st == ST_COLLECT) && (s_q.cnt != CW'(BUF_BYTES));
    pop             = q_valid && q_ready;
    char_hit        = term_match(s_q.cfg, q_data);
    rel_now         = 1'b0;
    blk_valid       = (s_q.st == ST_SEND);
    blk.data        = s_q.mem[s_q.idx];
    blk.last        = (s_q.idx == s_q.cnt - 1'b1) || is_page_end(s_q.idx);
    rts_out         = s_q.cfg.hs_en && rx_ready;
    avs_waitrequest = (avs_req.read || avs_req.write) && !s_q.ack;
    avs_readdata    = s_q.rdata;
    // millisecond tick and gap/message timers
    if (s_q.tick == TW'(TICK_CYC - 1)) begin
      s_d.tick = '0;
      tick_p   = 1'b1;
    end else begin
      s_d.tick = s_q.tick + 1'b1;
    end
    if (tick_p) begin
      s_d.gap_ms = sat_inc(s_q.gap_ms);
      s_d.msg_ms = sat_inc(s_q.msg_ms);
    end
    case (s_q.st)
      ST_COLLECT: begin
        if (pop) begin
          s_d.mem[s_q.cnt] = q_data;
          s_d.cnt          = ncnt;
          s_d.gap_ms       = '0;
          if (s_q.cnt == '0) begin
            s_d.msg_ms = '0;
          end
          rel_now = (s_q.cfg.term_type[3:0] == 4'h0)
                 || (s_q.cfg.term_type[TT_CHAR] && char_hit)
                 || (s_q.cfg.term_type[TT_LEN] && ncnt == CW'(s_q.cfg.pkt_len))
                 || (ncnt == CW'(BUF_BYTES));
        end else if (s_q.cnt != '0) begin
          rel_now = (s_q.cfg.term_type[TT_GAP] && s_q.gap_ms > s_q.cfg.gap_tmo)
                 || (s_q.cfg.term_type[TT_MSG] && s_q.msg_ms >= s_q.cfg.msg_tmo);
        end
        if (rel_now) begin
          s_d.st  = ST_SEND;
          s_d.idx = '0;
        end
      end
      ST_SEND: begin
        if (blk_ready) begin
          if (s_q.idx == s_q.cnt - 1'b1) begin
            s_d.st      = ST_COLLECT;
            s_d.cnt     = '0;
            s_d.idx     = '0;
            s_d.blk_cnt = s_q.blk_cnt + 1'b1;
          end else begin
            s_d.idx = s_q.idx + 1'b1;
          end
        end
      end
      default: s_d.st = ST_COLLECT;
    endcase
    // avalon: one wait cycle, then the access completes
    s_d.ack = (avs_req.read || avs_req.write) && !s_q.ack;
    if (avs_req.read && !s_q.ack) begin
      if (avs_req.address == REG_CTRL) begin
        s_d.rdata = {23'h0, s_q.cfg.hs_en, s_q.cfg.term_type};
      end else if (avs_req.address == REG_TERM_CNT) begin
        s_d.rdata = {29'h0, s_q.cfg.term_cnt};
      end else if (avs_req.address == REG_CHARS_LO) begin
        s_d.rdata = s_q.cfg.term_chars[3:0];
      end else if (avs_req.address == REG_CHARS_HI) begin
        s_d.rdata = {16'h0, s_q.cfg.term_chars[5:4]};
      end else if (avs_req.address == REG_PKT_LEN) begin
        s_d.rdata = {19'h0, s_q.cfg.pkt_len};
      end else if (avs_req.address == REG_MSG_TMO) begin
        s_d.rdata = {16'h0, s_q.cfg.msg_tmo};
      end else if (avs_req.address == REG_GAP_TMO) begin
        s_d.rdata = {16'h0, s_q.cfg.gap_tmo};
      end else if (avs_req.address == REG_STATUS) begin
        s_d.rdata                = '0;
        s_d.rdata[LEN_W-1:0]     = LEN_W'(s_q.cnt);
        s_d.rdata[ST_SEND_BIT]   = (s_q.st == ST_SEND);
        s_d.rdata[ST_CTS_BIT]    = s_q.cfg.hs_en && cts_in;
        s_d.rdata[31:ST_BLK_LSB] = s_q.blk_cnt;
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
    if (avs_req.write && s_q.ack) begin
      if (avs_req.address == REG_CTRL) begin
        s_d.cfg.term_type = avs_req.writedata[7:0];
        s_d.cfg.hs_en     = avs_req.writedata[CTRL_HS_BIT];
      end else if (avs_req.address == REG_TERM_CNT) begin
        s_d.cfg.term_cnt = avs_req.writedata[2:0];
      end else if (avs_req.address == REG_CHARS_LO) begin
        s_d.cfg.term_chars[3:0] = avs_req.writedata;
      end else if (avs_req.address == REG_CHARS_HI) begin
        s_d.cfg.term_chars[5:4] = avs_req.writedata[15:0];
      end else if (avs_req.address == REG_PKT_LEN) begin
        s_d.cfg.pkt_len = avs_req.writedata[LEN_W-1:0];
      end else if (avs_req.address == REG_MSG_TMO) begin
        s_d.cfg.msg_tmo = avs_req.writedata[TMO_W-1:0];
      end else if (avs_req.address == REG_GAP_TMO) begin
        s_d.cfg.gap_tmo = avs_req.writedata[TMO_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_q             <= '0;
      s_q.cfg.term_type <= TYPE_RST;
      s_q.cfg.pkt_len <= PKT_LEN_RST;
      s_q.cfg.msg_tmo <= MSG_TMO_RST;
      s_q.cfg.gap_tmo <= GAP_TMO_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // checks on the framing behaviour, handshake gating and bus answer
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_rel_start;
    ##1 (s_q.st == ST_SEND && s_q.idx == '0);
  endsequence
  sequence s_drain_done;
    (blk_valid && blk_ready && blk.last && s_q.idx == s_q.cnt - 1'b1) ##1 (s_q.st == ST_COLLECT && s_q.cnt == '0);
  endsequence

  a_stream_mode: assert property (pop && s_q.cfg.term_type[3:0] == 4'h0
    |-> s_rel_start ##0 (s_q.cnt == $past(s_q.cnt) + 1'b1))
    else $error("stream byte not forwarded at once");
  a_reserved_bits: assert property (pop && s_q.cfg.term_type[3:0] == 4'h0 && s_q.cfg.term_type[7:4] != 4'h0
    |-> s_rel_start)
    else $error("reserved type bits changed framing");
  a_char_release: assert property (pop && s_q.cfg.term_type[TT_CHAR] && char_hit
    |-> s_rel_start ##0 (s_q.cnt == $past(s_q.cnt) + 1'b1 && s_q.mem[s_q.cnt - 1'b1] == $past(q_data)))
    else $error("terminator did not end block");
  a_char_hold: assert property (pop && s_q.cfg.term_type == 8'h01 && !char_hit && s_q.cnt < CW'(BUF_BYTES - 1)
    |=> s_q.st == ST_COLLECT)
    else $error("block released without terminator");
  a_len_release: assert property (pop && s_q.cfg.term_type[TT_LEN] && s_q.cnt + 1'b1 == CW'(s_q.cfg.pkt_len)
    |-> s_rel_start ##0 (s_q.cnt == CW'(s_q.cfg.pkt_len)))
    else $error("length limit did not release");
  a_len_hold: assert property (pop && s_q.cfg.term_type == 8'h08 && s_q.cnt + 1'b1 < CW'(s_q.cfg.pkt_len)
    |=> s_q.st == ST_COLLECT)
    else $error("short remainder released");
  a_full_forced: assert property (pop && s_q.cnt == CW'(BUF_BYTES - 1) |-> s_rel_start ##0 (s_q.cnt == CW'(BUF_BYTES)))
    else $error("full buffer not transferred");
  a_page_last: assert property (blk_valid && is_page_end(s_q.idx) |-> blk.last)
    else $error("page longer than host limit");
  a_send_stall: assert property (s_q.st == ST_SEND |-> !q_ready ##0 blk_valid)
    else $error("bytes taken while block pending");
  a_block_end: assert property (blk_valid && blk_ready && s_q.idx == s_q.cnt - 1'b1 |-> s_drain_done)
    else $error("block end not handled");
  a_hs_gated: assert property (!s_q.cfg.hs_en |-> !rts_out)
    else $error("handshake line driven while disabled");
  a_gap_release: assert property (s_q.st == ST_COLLECT && !pop && s_q.cnt != '0 && s_q.cfg.term_type[TT_GAP]
    && s_q.gap_ms > s_q.cfg.gap_tmo |=> s_q.st == ST_SEND)
    else $error("gap timeout missed");
  a_msg_release: assert property (s_q.st == ST_COLLECT && !pop && s_q.cnt != '0 && s_q.cfg.term_type[TT_MSG]
    && s_q.msg_ms >= s_q.cfg.msg_tmo |=> s_q.st == ST_SEND)
    else $error("message timeout missed");
  a_bus_answer: assert property ((avs_req.read || avs_req.write) |-> ##[0:1] !avs_waitrequest)
    else $error("avalon access not answered");

  // timer restart, handshake, block hold and bus checks
  a_wait_first: assert property ((avs_req.read || avs_req.write) && !$past(avs_req.read || avs_req.write)
    |-> avs_waitrequest)
    else $error("first access cycle not stalled");
  a_readdata_hold: assert property (!(avs_req.read && !s_q.ack) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_status_ro: assert property (avs_req.write && s_q.ack && avs_req.address == REG_STATUS
    |=> s_q.cfg == $past(s_q.cfg))
    else $error("status write altered settings");
  a_cts_hidden: assert property (avs_req.read && !s_q.ack && avs_req.address == REG_STATUS
    && !s_q.cfg.hs_en |=> !avs_readdata[ST_CTS_BIT])
    else $error("modem line reported while disabled");
  a_rts_follow: assert property (s_q.cfg.hs_en |-> rts_out == rx_ready)
    else $error("request line does not follow room");
  a_msg_first: assert property (pop && s_q.cnt == '0 |=> s_q.msg_ms == '0)
    else $error("message timer not restarted");
  a_gap_restart: assert property (pop |=> s_q.gap_ms == '0)
    else $error("gap timer not restarted");
  a_blk_hold: assert property (blk_valid && !blk_ready |=> blk_valid && $stable(blk))
    else $error("block byte changed while stalled");
  a_send_step: assert property (blk_valid && blk_ready && s_q.idx != s_q.cnt - 1'b1
    |=> blk_valid && s_q.idx == $past(s_q.idx) + 1'b1)
    else $error("block bytes out of order");
endmodule : srtf_framer

//--- design/srtf_pkg.sv
// shared constants, types and register map of the receive framer
package srtf_pkg;
  localparam int          BYTE_W          = 8;
  localparam int          RX_BUF_BYTES    = 4096;         // receive buffer size
  localparam int          FIFO_WORDS      = 32;           // input fifo depth
  localparam int          HOST_PAGE_BYTES = 64;           // largest host read page
  localparam int          MAX_TERM_CHARS  = 6;
  localparam int          LEN_W           = 13;
  localparam int          TMO_W           = 16;
  // timing: timeouts count in 1 ms ticks
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          TICK_NS         = 1_000_000;
  localparam int          TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
  // termination type bits
  localparam int          TT_CHAR         = 0;
  localparam int          TT_MSG          = 1;
  localparam int          TT_GAP          = 2;
  localparam int          TT_LEN          = 3;
  localparam int          CTRL_HS_BIT     = 8;
  localparam int          ST_SEND_BIT     = 16;
  localparam int          ST_CTS_BIT      = 17;
  localparam int          ST_BLK_LSB      = 24;
  // register byte offsets
  localparam logic [7:0]  REG_CTRL        = 8'h00;
  localparam logic [7:0]  REG_TERM_CNT    = 8'h04;
  localparam logic [7:0]  REG_CHARS_LO    = 8'h08;
  localparam logic [7:0]  REG_CHARS_HI    = 8'h0c;
  localparam logic [7:0]  REG_PKT_LEN     = 8'h10;
  localparam logic [7:0]  REG_MSG_TMO     = 8'h14;
  localparam logic [7:0]  REG_GAP_TMO     = 8'h18;
  localparam logic [7:0]  REG_STATUS      = 8'h1c;
  // reset values
  localparam logic [7:0]  TYPE_RST        = 8'h00;
  localparam logic [12:0] PKT_LEN_RST     = 13'h0000;
  localparam logic [15:0] MSG_TMO_RST     = 16'h0064;
  localparam logic [15:0] GAP_TMO_RST     = 16'h000a;

  typedef enum logic {ST_COLLECT, ST_SEND} srtf_state_e;

  typedef struct packed {
    logic [7:0]                               term_type;
    logic                                     hs_en;
    logic [2:0]                               term_cnt;
    logic [MAX_TERM_CHARS-1:0][BYTE_W-1:0]    term_chars;
    logic [LEN_W-1:0]                         pkt_len;
    logic [TMO_W-1:0]                         msg_tmo;
    logic [TMO_W-1:0]                         gap_tmo;
  } srtf_cfg_s;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } srtf_avs_req_s;

  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic              last;
  } srtf_blk_s;
endpackage : srtf_pkg

//--- testbench/srtf_serial_dev.sv
// serial device model that feeds received bytes into the framer
`timescale 1ns/1ns
module srtf_serial_dev (
  input  wire logic       ref_clk,  // system clock
  input  wire logic       rst,      // async reset, high
  input  wire logic       rx_ready, // framer fifo has room
  output      logic       rx_valid, // byte offered
  output      logic [7:0] rx_data   // byte on the line
);
  logic [7:0] q[$]; // bytes waiting to go out

  // queue one byte for the line
  task automatic send(input logic [7:0] b);
    q.push_back(b);
  endtask : send

  // bytes go out in order; an idle line toggles so stale data never looks current
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      if (rx_valid && rx_ready && q.size() > 0) begin
        void'(q.pop_front());
      end
      if (q.size() > 0) begin
        rx_valid <= 1'b1;
        rx_data  <= q[0];
      end else begin
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;
      end
    end
  end
endmodule : srtf_serial_dev

//--- testbench/test_serial_receive_termination_framer.sv
// register and block level bench for the receive framer
`timescale 1ns/1ns
module test_serial_receive_termination_framer;
  import srtf_pkg::*;
  logic                ref_clk, rst, rx_valid, rx_ready, cts_in, rts_out, blk_valid, blk_ready;
  logic [7:0]          rx_data;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  srtf_avs_req_s       avs_req;
  srtf_blk_s           blk;
  int                  n_fail = 0;
  int                  compares = 0;
  logic [7:0]          big[$];

  // short tick and small buffer keep the run brief
  srtf_framer #(.BUF_BYTES(64), .PAGE_BYTES(HOST_PAGE_BYTES), .FIFO_DEPTH(FIFO_WORDS), .TICK_CYC(10)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .cts_in(cts_in), .rts_out(rts_out), .blk_valid(blk_valid), .blk(blk), .blk_ready(blk_ready));
  srtf_serial_dev dev_u (.ref_clk(ref_clk), .rst(rst), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data));

  // clock generation
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  // one avalon access, held until waitrequest is seen low at a rising edge
  task automatic avs(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge ref_clk);
    avs_req <= '{read: ~wr, write: wr, address: a, writedata: d};
    n = 0;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
    if (n >= 50) begin
      n_fail++;
      print_verdict();
    end
    rd = avs_readdata;
    avs_req <= '0;
  endtask : avs

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    avs(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] x;
    avs(1'b0, a, 32'h0000_0000, x);
    cmp_word(what, exp, x);
  endtask : rd_chk

  task automatic push(input logic [7:0] e[$]);
    foreach (e[i]) dev_u.send(e[i]);
  endtask : push

  // take one block from the host side and compare byte by byte
  task automatic collect(input logic [7:0] e[$]);
    int n;
    for (int i = 0; i < e.size(); i++) begin
      n = 0;
      do @(negedge ref_clk); while (blk_valid !== 1'b1 && ++n < 400);
      if (n >= 400) begin
        n_fail++;
        print_verdict();
      end
      cmp_word("blk data", {24'h00_0000, e[i]}, {24'h00_0000, blk.data});
      cmp_bit("blk last", 1'(i == e.size() - 1), blk.last);
      @(posedge ref_clk);
    end
  endtask : collect

  // poll held byte count until it settles, bounded
  task automatic held_is(input logic [12:0] n);
    logic [31:0] x;
    for (int k = 0; k < 40; k++) begin
      avs(1'b0, REG_STATUS, 32'h0000_0000, x);
      if (x[12:0] === n) break;
    end
    cmp_word("held bytes", {19'h0_0000, n}, {19'h0_0000, x[12:0]});
  endtask : held_is

  // watchdog on the whole run
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    print_verdict();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    avs_req = '0;
    cts_in = 1'b0;
    blk_ready = 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(REG_CTRL, 32'h0000_0000, "ctrl reset");
    rd_chk(REG_PKT_LEN, 32'h0000_0000, "pkt len reset");
    rd_chk(REG_MSG_TMO, 32'h0000_0064, "msg tmo reset");
    rd_chk(REG_GAP_TMO, 32'h0000_000a, "gap tmo reset");
    rd_chk(8'h20, 32'h0000_0000, "unmapped read");
    cmp_bit("rts disabled", 1'b0, rts_out);
    push('{8'h41});
    collect('{8'h41});
    wr(REG_CTRL, 32'h0000_00f0);
    rd_chk(REG_CTRL, 32'h0000_00f0, "ctrl reserved bits");
    push('{8'h42, 8'h43});
    collect('{8'h42});
    collect('{8'h43});
    // terminator list: two active chars, a third stored but inactive
    wr(REG_TERM_CNT, 32'h0000_0002);
    wr(REG_CHARS_LO, 32'h0033_0a0d);
    wr(REG_CTRL, 32'h0000_0001);
    push('{8'h41, 8'h33, 8'h0a, 8'h44, 8'h0d, 8'h45, 8'h46});
    collect('{8'h41, 8'h33, 8'h0a});
    collect('{8'h44, 8'h0d});
    held_is(13'd2);
    // length limit
    wr(REG_PKT_LEN, 32'h0000_0004);
    wr(REG_CTRL, 32'h0000_0008);
    push('{8'h47, 8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e});
    collect('{8'h45, 8'h46, 8'h47, 8'h48});
    collect('{8'h49, 8'h4a, 8'h4b, 8'h4c});
    held_is(13'd2);
    // gap timeout flushes the remainder
    wr(REG_GAP_TMO, 32'h0000_0002);
    wr(REG_CTRL, 32'h0000_0004);
    collect('{8'h4d, 8'h4e});
    wr(REG_MSG_TMO, 32'h0000_0003);
    wr(REG_CTRL, 32'h0000_0002);
    push('{8'h50, 8'h51});
    collect('{8'h50, 8'h51});
    // terminator and length together
    wr(REG_CTRL, 32'h0000_0009);
    push('{8'h52, 8'h0d, 8'h53, 8'h54, 8'h55, 8'h56});
    collect('{8'h52, 8'h0d});
    collect('{8'h53, 8'h54, 8'h55, 8'h56});
    // full buffer with host stalled, fifo fills behind it
    wr(REG_CTRL, 32'h0000_0001);
    @(posedge ref_clk);
    blk_ready <= 1'b0;
    for (int i = 0; i < 97; i++) big.push_back(8'h60 | 8'(i % 32));
    push(big);
    for (int n = 0; n < 400 && rx_ready !== 1'b0; n++) @(negedge ref_clk);
    cmp_bit("rx_ready full", 1'b0, rx_ready);
    cmp_bit("rts disabled full", 1'b0, rts_out);
    @(posedge ref_clk);
    blk_ready <= 1'b1;
    collect(big[0:63]);
    push('{8'h0d});
    big = big[64:96];
    big.push_back(8'h0d);
    collect(big);
    rd_chk(REG_STATUS, 32'h0d00_0000, "status blocks");
    wr(REG_STATUS, 32'hffff_ffff);
    @(posedge ref_clk);
    cts_in <= 1'b1;
    rd_chk(REG_STATUS, 32'h0d00_0000, "status cts off");
    wr(REG_CTRL, 32'h0000_0101);
    rd_chk(REG_STATUS, 32'h0d02_0000, "status cts on");
    cmp_bit("rts enabled", 1'b1, rts_out);
    // all six terminator slots active, the last one ends the block
    wr(REG_TERM_CNT, 32'h0000_0006);
    wr(REG_CHARS_HI, 32'h0000_2a00);
    rd_chk(REG_TERM_CNT, 32'h0000_0006, "term count");
    rd_chk(REG_CHARS_HI, 32'h0000_2a00, "chars hi");
    push('{8'h61, 8'h2a});
    collect('{8'h61, 8'h2a});
    print_verdict();
  end
endmodule : test_serial_receive_termination_framer
